//--- verilog/fwsr_ctrl.sv
// Host controller that runs flash command sequences and the status polling procedure.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps

// How it works
// - Host double-reads; unchanged toggle means done
// - Timeout high and still toggling: reset
// - Resumed polling restarts at first double-read
// - Host resets after a timeout failure
// - Host checks erase_window_flag around add
// - Write only with select, strobe low, read high
module fwsr_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [17:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic [7:0] dq_in
);

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_WSET, S_WLOW, S_WEND, S_RLOW, S_REL} fwsr_state_e;

  // ----------------------------------------------------------------
  // Command sequences
  // ----------------------------------------------------------------
  function automatic fwsr_pkg::fwsr_step_s step_f(input logic [2:0] op, input logic [2:0] idx,
                                                   input logic [17:0] a, input logic [7:0] d);
    fwsr_pkg::fwsr_step_s s;
    s.rd = 1'b0;
    s.last = 1'b0;
    s.a = fwsr_pkg::ADDR_UNLOCK1;
    s.d = fwsr_pkg::CMD_UNLOCK1;
    if (idx == 3'h1 || idx == 3'h4) begin
      s.a = fwsr_pkg::ADDR_UNLOCK2;
      s.d = fwsr_pkg::CMD_UNLOCK2;
    end
    unique case (op)
      fwsr_pkg::OP_READ: begin
        s.rd = 1'b1;
        s.last = 1'b1;
        s.a = a;
      end
      fwsr_pkg::OP_PROG: begin
        if (idx == 3'h2) s.d = fwsr_pkg::CMD_PROG;
        if (idx == 3'h3) begin
          s.a = a;
          s.d = d;
          s.last = 1'b1;
        end
      end
      fwsr_pkg::OP_SERASE, fwsr_pkg::OP_CERASE: begin
        if (idx == 3'h2) s.d = fwsr_pkg::CMD_ERASE_SETUP;
        if (idx == 3'h5) begin
          s.last = 1'b1;
          s.a = (op == fwsr_pkg::OP_SERASE) ? a : fwsr_pkg::ADDR_UNLOCK1;
          s.d = (op == fwsr_pkg::OP_SERASE) ? fwsr_pkg::CMD_SECTOR : fwsr_pkg::CMD_CHIP;
        end
      end
      fwsr_pkg::OP_ADDSEC: begin
        s.a = a;
        s.d = fwsr_pkg::CMD_SECTOR;
        s.rd = (idx != 3'h1);
        s.last = (idx == 3'h2);
      end
      fwsr_pkg::OP_RESET: begin
        s.a = a;
        s.d = fwsr_pkg::CMD_RESET;
        s.last = 1'b1;
      end
      fwsr_pkg::OP_PROTV: begin
        if (idx == 3'h2) s.d = fwsr_pkg::CMD_ID;
        if (idx == 3'h3) begin
          s.rd = 1'b1;
          s.last = 1'b1;
          s.a = a | fwsr_pkg::ADDR_LINE_ONE;
        end
      end
      fwsr_pkg::OP_RAW: begin
        s.a = a;
        s.d = d;
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction : step_f

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fwsr_state_e state_ff;
  logic [2:0] op_ff;
  logic [2:0] step_ff;
  logic [3:0] cnt_ff;
  logic [17:0] addr_reg_ff;
  logic [7:0] wdata_reg_ff;
  logic polling_ff;
  logic poll_done_ff;
  logic have_prev_ff;
  logic prev_tog_ff;
  logic checked5_ff;
  logic [7:0] poll_reads_ff;
  logic done_ff;
  logic fail_ff;
  logic reject_ff;
  logic prot_ff;
  logic window_ff;
  logic tog2_ff;
  logic pre_win_ff;
  logic [7:0] rdata_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [17:0] flash_addr_ff;
  logic flash_ce_n_ff;
  logic flash_oe_n_ff;
  logic flash_we_n_ff;
  logic [7:0] dq_out_ff;
  logic dq_oe_n_ff;
  logic [7:0] rd_val;
  fwsr_pkg::fwsr_step_s cur;
  logic busy;
  logic apb_acc;
  logic start;
  logic sample;
  logic poll_read;
  logic tog_same;
  logic poll_ok;
  logic poll_bad;
  logic poll_op;

  fwsr_sync #(.WIDTH(fwsr_pkg::DATA_W)) u_sync (
    .clk(clk),
    .srst(srst),
    .d_in(dq_in),
    .q(rd_val)
  );

  assign cur = step_f(op_ff, step_ff, addr_reg_ff, wdata_reg_ff);
  assign busy = (state_ff != S_IDLE);
  assign apb_acc = psel && penable && pready_ff;
  assign start = apb_acc && pwrite && (paddr == fwsr_pkg::REG_CTRL) && !busy;
  assign sample = (state_ff == S_RLOW) && (cnt_ff == fwsr_pkg::RD_WAIT_CNT);
  assign poll_read = sample && polling_ff;
  assign tog_same = (rd_val[fwsr_pkg::BIT_TOG1] == prev_tog_ff);
  assign poll_ok = poll_read && have_prev_ff && tog_same;
  assign poll_bad = poll_read && have_prev_ff && !tog_same && checked5_ff;
  assign poll_op = (op_ff == fwsr_pkg::OP_PROG) || (op_ff == fwsr_pkg::OP_SERASE) ||
                   (op_ff == fwsr_pkg::OP_CERASE);

  // ----------------------------------------------------------------
  // APB slave: one wait cycle so that read data come from a flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      if (psel && penable && !pready_ff) begin
        prdata_ff <= 32'h0;
        unique case (paddr)
          fwsr_pkg::REG_CTRL: prdata_ff[2:0] <= op_ff;
          fwsr_pkg::REG_ADDR: prdata_ff[17:0] <= addr_reg_ff;
          fwsr_pkg::REG_WDATA: prdata_ff[7:0] <= wdata_reg_ff;
          fwsr_pkg::REG_STATUS: begin
            prdata_ff[fwsr_pkg::ST_BUSY] <= busy;
            prdata_ff[fwsr_pkg::ST_DONE] <= done_ff;
            prdata_ff[fwsr_pkg::ST_FAIL] <= fail_ff;
            prdata_ff[fwsr_pkg::ST_REJECT] <= reject_ff;
            prdata_ff[fwsr_pkg::ST_PROT] <= prot_ff;
            prdata_ff[fwsr_pkg::ST_WINDOW] <= window_ff;
            prdata_ff[fwsr_pkg::ST_TOG2] <= tog2_ff;
            prdata_ff[fwsr_pkg::ST_PRE_WIN] <= pre_win_ff;
            prdata_ff[fwsr_pkg::ST_RDATA_LSB +: 8] <= rdata_ff;
          end
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // Address and data registers may be rewritten while busy; the running sequence then sees them.
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg_ff <= 18'h0;
      wdata_reg_ff <= 8'h0;
    end else if (apb_acc && pwrite) begin
      if (paddr == fwsr_pkg::REG_ADDR) addr_reg_ff <= pwdata[17:0];
      if (paddr == fwsr_pkg::REG_WDATA) wdata_reg_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and flash pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= S_IDLE;
      op_ff <= fwsr_pkg::OP_READ;
      step_ff <= 3'h0;
      cnt_ff <= 4'h0;
      polling_ff <= 1'b0;
      poll_done_ff <= 1'b0;
      flash_addr_ff <= 18'h0;
      flash_ce_n_ff <= 1'b1;
      flash_oe_n_ff <= 1'b1;
      flash_we_n_ff <= 1'b1;
      dq_out_ff <= 8'h0;
      dq_oe_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (start) begin
            op_ff <= pwdata[2:0];
            step_ff <= 3'h0;
            poll_done_ff <= 1'b0;
            state_ff <= S_STEP;
          end
        end
        S_STEP: begin
          flash_addr_ff <= cur.a;
          cnt_ff <= 4'h0;
          if (cur.rd) begin
            flash_ce_n_ff <= 1'b0;
            flash_oe_n_ff <= 1'b0;
            state_ff <= S_RLOW;
          end else begin
            // write setup with read strobe high
            flash_ce_n_ff <= 1'b0;
            flash_oe_n_ff <= 1'b1;
            dq_out_ff <= cur.d;
            dq_oe_n_ff <= 1'b0;
            state_ff <= S_WSET;
          end
        end
        S_WSET: begin
          flash_we_n_ff <= 1'b0;
          state_ff <= S_WLOW;
        end
        S_WLOW: begin
          flash_we_n_ff <= 1'b1;
          state_ff <= S_WEND;
        end
        S_WEND: begin
          flash_ce_n_ff <= 1'b1;
          dq_oe_n_ff <= 1'b1;
          state_ff <= S_REL;
        end
        S_RLOW: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (sample) begin
            flash_ce_n_ff <= 1'b1;
            flash_oe_n_ff <= 1'b1;
            state_ff <= S_REL;
            if (poll_ok || poll_bad) begin
              polling_ff <= 1'b0;
              poll_done_ff <= 1'b1;
            end
            // reset before further commands
            // The reset write has to reach the flash before idle, so the release state is skipped here.
            if (poll_bad) begin
              op_ff <= fwsr_pkg::OP_RESET;
              step_ff <= 3'h0;
              state_ff <= S_STEP;
            end
          end
        end
        S_REL: begin
          cnt_ff <= 4'h0;
          // Each poll read is its own strobe, so the device sees a fresh read every time.
          if (polling_ff || (cur.last && poll_op && !poll_done_ff)) begin
            polling_ff <= 1'b1;
            flash_ce_n_ff <= 1'b0;
            flash_oe_n_ff <= 1'b0;
            state_ff <= S_RLOW;
          end else if (cur.last) begin
            state_ff <= S_IDLE;
          end else begin
            step_ff <= step_ff + 3'h1;
            state_ff <= S_STEP;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Toggle detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      have_prev_ff <= 1'b0;
      prev_tog_ff <= 1'b0;
      checked5_ff <= 1'b0;
      poll_reads_ff <= 8'h0;
    end else if (state_ff == S_REL && !polling_ff && cur.last && poll_op && !poll_done_ff) begin
      have_prev_ff <= 1'b0;
      checked5_ff <= 1'b0;
      poll_reads_ff <= 8'h0;
    end else if (poll_read) begin
      have_prev_ff <= 1'b1;
      prev_tog_ff <= rd_val[fwsr_pkg::BIT_TOG1];
      if (poll_reads_ff != 8'hff) poll_reads_ff <= poll_reads_ff + 8'h1;
      if (have_prev_ff && !tog_same && rd_val[fwsr_pkg::BIT_TIMEOUT]) checked5_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      reject_ff <= 1'b0;
      prot_ff <= 1'b0;
      window_ff <= 1'b0;
      tog2_ff <= 1'b0;
      pre_win_ff <= 1'b0;
      rdata_ff <= 8'h0;
    end else begin
      if (start) begin
        done_ff <= 1'b0;
        fail_ff <= 1'b0;
        reject_ff <= 1'b0;
      end else if (state_ff == S_REL && !polling_ff && cur.last && !(poll_op && !poll_done_ff)) begin
        done_ff <= 1'b1;
      end
      if (poll_bad) fail_ff <= 1'b1;
      if (sample) begin
        rdata_ff <= rd_val;
        window_ff <= rd_val[fwsr_pkg::BIT_WINDOW];
        tog2_ff <= rd_val[fwsr_pkg::BIT_TOG2];
        if (op_ff == fwsr_pkg::OP_PROTV) prot_ff <= rd_val[fwsr_pkg::BIT_LINE_ZERO];
        if (op_ff == fwsr_pkg::OP_ADDSEC && step_ff == 3'h0) pre_win_ff <= rd_val[fwsr_pkg::BIT_WINDOW];
        if (op_ff == fwsr_pkg::OP_ADDSEC && step_ff == 3'h2) reject_ff <= rd_val[fwsr_pkg::BIT_WINDOW];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign flash_addr = flash_addr_ff;
  assign flash_ce_n = flash_ce_n_ff;
  assign flash_oe_n = flash_oe_n_ff;
  assign flash_we_n = flash_we_n_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe_n = dq_oe_n_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  write_inhibit_a: assert property (!flash_we_n_ff |-> flash_oe_n_ff && !flash_ce_n_ff)
    else $error("write strobe low without select or with read strobe low");
  bus_fight_a: assert property (!flash_oe_n_ff |-> dq_oe_n_ff)
    else $error("data driven while read strobe low");
  we_pulse_a: assert property ($fell(flash_we_n_ff) |-> !dq_oe_n_ff ##1 flash_we_n_ff && !dq_oe_n_ff)
    else $error("write pulse not one cycle with data held");
  fail_reset_a: assert property ($rose(fail_ff) |-> ##[1:6] (!flash_we_n_ff && dq_out_ff == fwsr_pkg::CMD_RESET))
    else $error("no reset command after failure");
  double_read_a: assert property (poll_ok |-> poll_reads_ff >= 8'h1)
    else $error("poll ended before two reads");
  recheck_a: assert property ($rose(fail_ff) |-> $past(checked5_ff) && $past(poll_reads_ff) >= 8'h2)
    else $error("failure without timeout recheck");
  restart_a: assert property ($rose(polling_ff) |-> !have_prev_ff && poll_reads_ff == 8'h0)
    else $error("poll did not restart from first read");
  reject_a: assert property ($rose(reject_ff) |-> $past(op_ff) == fwsr_pkg::OP_ADDSEC && window_ff)
    else $error("reject flag without window flag high");
  apb_wait_a: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb ready not a single cycle");

  prog_poll_c: cover property (op_ff == fwsr_pkg::OP_PROG && poll_ok);
  fail_c: cover property ($rose(fail_ff));
  addsec_c: cover property (op_ff == fwsr_pkg::OP_ADDSEC && state_ff == S_REL && cur.last);
  protv_c: cover property (op_ff == fwsr_pkg::OP_PROTV && sample);

endmodule : fwsr_ctrl

//--- verilog/fwsr_pkg.sv
// Constants, register map and step record for the flash status controller.
package fwsr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register map of the controller (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Operation codes written to the control register.
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_SERASE = 3'h2;
  localparam logic [2:0] OP_CERASE = 3'h3;
  localparam logic [2:0] OP_ADDSEC = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  localparam logic [2:0] OP_PROTV = 3'h6;
  localparam logic [2:0] OP_RAW = 3'h7;

  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_PROT = 4;
  localparam int ST_WINDOW = 5;
  localparam int ST_TOG2 = 6;
  localparam int ST_PRE_WIN = 7;
  localparam int ST_RDATA_LSB = 8;

  // ----------------------------------------------------------------
  // Flash command bytes and addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [17:0] ADDR_UNLOCK1 = 18'h00555;
  localparam logic [17:0] ADDR_UNLOCK2 = 18'h002aa;
  localparam logic [17:0] ADDR_LINE_ONE = 18'h00002;

  // Status bit positions on the flash data lines.
  localparam int BIT_POLL = 7;
  localparam int BIT_TOG1 = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_WINDOW = 3;
  localparam int BIT_TOG2 = 2;
  localparam int BIT_LINE_ZERO = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int TACC_NS = 120;
  localparam int ACC_CYC = (TACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_DEPTH = 3;
  localparam logic [3:0] RD_WAIT_CNT = 4'(ACC_CYC + SYNC_DEPTH + 1);

  typedef struct packed {
    logic rd;
    logic last;
    logic [17:0] a;
    logic [7:0] d;
  } fwsr_step_s;

endpackage : fwsr_pkg

//--- verilog/fwsr_sync.sv
// Three-stage input synchroniser that passes a value once stages two and three agree.
`timescale 1ns/100ps
module fwsr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Only a value that held for two stages is passed, so a bit caught mid-change never leaks out.
  always_ff @(posedge clk) begin
    if (srst) begin
      q_ff <= '0;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign q = q_ff;

endmodule : fwsr_sync

//--- tb/fwsr_flash_model.sv
// Behavioural parallel flash that answers the controller's strobes with array data or status bytes.
`timescale 1ns/100ps
module fwsr_flash_model #(
  parameter int PROG_READS = 3,
  parameter int ERASE_READS = 5,
  parameter int TO_READS = 4,
  parameter logic [1:0] PROT_SEC = 2'h3,
  // Arbitrary identification byte of our own making.
  parameter logic [7:0] ID_CODE = 8'h5e
) (
  input wire logic [17:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] dq,
  output logic [7:0] m_dq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Busy time is counted in reads, so the run length does not hang on the clock rate.
  logic [7:0] mem [64];
  logic [7:0] dout = 8'h00;
  logic [7:0] lastd = 8'hff;
  logic [3:0] esec = 4'h0;
  logic busy = 1'b0, erase = 1'b0, lock = 1'b0, tog1 = 1'b0, tog2 = 1'b0, tout = 1'b0, idm = 1'b0;
  int st = 0, left = 0, nrd = 0;
  wire logic rd_n = flash_ce_n | flash_oe_n;

  function automatic int idx(input logic [17:0] a);
    return {a[17:16], a[3:0]};
  endfunction : idx

  initial foreach (mem[i]) mem[i] = 8'hff;

  // Released lines show the inverse of the last byte so a stale value never passes.
  assign m_dq = rd_n ? ~dout : dout;

  // ----------------------------------------------------------------
  // Write cycles
  // ----------------------------------------------------------------
  // Write needs select
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_oe_n) begin
      if (dq == 8'hf0) begin
        st = 0; busy = 0; lock = 0; tout = 0; idm = 0;
      end else if (busy) begin
        // Window still open: another sector joins
        if (erase && nrd == 0 && dq == 8'h30 && flash_addr[17:16] != PROT_SEC) begin
          esec[flash_addr[17:16]] = 1'b1;
          for (int i = 0; i < 64; i++) if (i / 16 == flash_addr[17:16]) mem[i] = 8'hff;
        end
        st = 0;
      end else if (st == 3) begin
        lastd = dq; busy = 1; erase = 0; nrd = 0; esec = 4'h0; left = PROG_READS; st = 0;
        if (flash_addr[17:16] == PROT_SEC) left = 2;
        else if (mem[idx(flash_addr)] != 8'hff) lock = 1;
        else mem[idx(flash_addr)] = dq;
      end else if (st == 6) begin
        esec = (dq == 8'h10) ? 4'hf : 4'h1 << flash_addr[17:16];
        esec[PROT_SEC] = 1'b0;
        busy = 1; erase = 1; nrd = 0; st = 0;
        left = (esec == 4'h0) ? 2 : ERASE_READS;
        for (int i = 0; i < 64; i++) if (esec[i / 16]) mem[i] = 8'hff;
      end else begin
        case (st)
          0, 4: st = (dq == 8'haa && flash_addr == 18'h00555) ? st + 1 : 0;
          1, 5: st = (dq == 8'h55 && flash_addr == 18'h002aa) ? st + 1 : 0;
          2: begin
            idm = (dq == 8'h90);
            st = (dq == 8'ha0) ? 3 : (dq == 8'h80) ? 4 : 0;
          end
          default: st = 0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read cycles
  // ----------------------------------------------------------------
  always @(negedge rd_n) begin
    if (idm) begin
      dout = flash_addr[1] ? {7'h00, flash_addr[17:16] == PROT_SEC} : ID_CODE;
    end else if (busy) begin
      tog1 = ~tog1;
      if (esec[flash_addr[17:16]]) tog2 = ~tog2;
      dout = {erase ? 1'b0 : ~lastd[7], tog1, tout, 1'b0, erase & (nrd > 0), tog2, 2'b00};
      nrd++;
      if (lock) tout = (nrd >= TO_READS);
      else if (nrd >= left) busy = 0;
    end else begin
      dout = mem[idx(flash_addr)];
    end
  end
endmodule : fwsr_flash_model

//--- tb/tb_flash_write_status_reporting.sv
// Self-checking bench for the flash status controller against a behavioural flash.
`timescale 1ns/100ps
module tb_flash_write_status_reporting;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, err;
  logic [17:0] faddr;
  logic [7:0] dq_out, m_dq;
  wire logic [7:0] dq;
  int n_fail = 0, comparisons = 0;

  assign dq = !dq_oe_n ? dq_out : m_dq;
  always #50 clk = ~clk;

  fwsr_ctrl i_fwsr_ctrl (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(faddr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq));

  fwsr_flash_model i_fwsr_flash_model (.flash_addr(faddr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .dq(dq), .m_dq(m_dq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // The request stands until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polling has no bound of its own; the watchdog ends a hang.
  task automatic run_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
    apb(1'b1, fwsr_pkg::REG_ADDR, {14'h0, a}, rv, err);
    apb(1'b1, fwsr_pkg::REG_WDATA, {24'h0, d}, rv, err);
    apb(1'b1, fwsr_pkg::REG_CTRL, {29'h0, op}, rv, err);
    do apb(1'b0, fwsr_pkg::REG_STATUS, 32'h0, rv, err);
    while (!(rv[fwsr_pkg::ST_BUSY] === 1'b0 && rv[fwsr_pkg::ST_DONE] === 1'b1));
  endtask : run_op

  task automatic op_st(input string name, input logic [2:0] op, input logic [17:0] a,
                       input logic [7:0] d, input logic [31:0] exp);
    run_op(op, a, d);
    check(name, rv & 32'h7, exp);
  endtask : op_st

  task automatic rd_byte(input string name, input logic [17:0] a, input logic [7:0] exp);
    run_op(fwsr_pkg::OP_READ, a, 8'h00);
    check(name, (rv >> 8) & 32'hff, {24'h0, exp});
  endtask : rd_byte

  task automatic prot_chk(input string name, input logic [17:0] a, input logic [31:0] exp);
    run_op(fwsr_pkg::OP_PROTV, a, 8'h00);
    check(name, (rv >> fwsr_pkg::ST_PROT) & 32'h1, exp);
    run_op(fwsr_pkg::OP_RESET, a, 8'h00);
  endtask : prot_chk

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, fwsr_pkg::REG_STATUS, 32'h0, rv, err);
    check("status after reset", rv, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rv, err);
    check("unmapped error", {31'h0, err}, 32'h1);
    op_st("program status", fwsr_pkg::OP_PROG, 18'h00005, 8'h5a, 32'h2);
    rd_byte("programmed byte", 18'h00005, 8'h5a);
    op_st("second program", fwsr_pkg::OP_PROG, 18'h10007, 8'ha5, 32'h2);
    op_st("lockup status", fwsr_pkg::OP_PROG, 18'h00005, 8'h00, 32'h6);
    rd_byte("byte after lockup", 18'h00005, 8'h5a);
    op_st("sector erase status", fwsr_pkg::OP_SERASE, 18'h00005, 8'h00, 32'h2);
    rd_byte("erased byte", 18'h00005, 8'hff);
    rd_byte("unselected sector", 18'h10007, 8'ha5);
    op_st("protected program", fwsr_pkg::OP_PROG, 18'h30002, 8'h11, 32'h2);
    rd_byte("protected byte", 18'h30002, 8'hff);
    op_st("protected erase", fwsr_pkg::OP_SERASE, 18'h30002, 8'h00, 32'h2);
    prot_chk("protected sector", 18'h30000, 32'h1);
    prot_chk("open sector", 18'h00000, 32'h0);
    // Raw writes start a sector erase without polling, so the added sector meets a running erase.
    run_op(fwsr_pkg::OP_RAW, 18'h00555, 8'haa);
    run_op(fwsr_pkg::OP_RAW, 18'h002aa, 8'h55);
    run_op(fwsr_pkg::OP_RAW, 18'h00555, 8'h80);
    run_op(fwsr_pkg::OP_RAW, 18'h00555, 8'haa);
    run_op(fwsr_pkg::OP_RAW, 18'h002aa, 8'h55);
    run_op(fwsr_pkg::OP_RAW, 18'h20000, 8'h30);
    run_op(fwsr_pkg::OP_ADDSEC, 18'h20000, 8'h00);
    check("window before add", (rv >> fwsr_pkg::ST_PRE_WIN) & 32'h1, 32'h0);
    check("add rejected", (rv >> fwsr_pkg::ST_REJECT) & 32'h1, 32'h1);
    op_st("reset after add", fwsr_pkg::OP_RESET, 18'h20000, 8'h00, 32'h2);
    op_st("chip erase status", fwsr_pkg::OP_CERASE, 18'h00000, 8'h00, 32'h2);
    rd_byte("chip erased byte", 18'h10007, 8'hff);
    apb(1'b0, fwsr_pkg::REG_CTRL, 32'h0, rv, err);
    check("last operation", rv & 32'h7, {29'h0, fwsr_pkg::OP_READ});
    finish_test();
  end
endmodule : tb_flash_write_status_reporting
